// *** core/two_level_interrupt_unit.sv ***
// two-level, six-source interrupt controller with power control register
`timescale 1ns/1ps
module two_level_interrupt_unit
  import irq_unit_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic internalReset,
  input wire logic stateFivePhaseTwo,
  input wire logic pollCycle,
  input wire logic finalCycle,
  input wire logic returnFromHandler,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic external_zero_flag,
  input wire logic external_zero_edge_mode,
  input wire logic timer_zero_overflow_flag,
  input wire logic external_one_flag,
  input wire logic external_one_edge_mode,
  input wire logic timer_one_overflow_flag,
  input wire logic display_channel_flag,
  input wire logic serial_receive_flag,
  input wire logic serial_transmit_flag,
  input wire logic second_serial_flag,
  output logic [7:0] regReadData,
  output logic ackRequest,
  output logic [15:0] vectorAddress,
  output logic pushProgramCounter,
  output logic popProgramCounter,
  output logic clearExternalZero,
  output logic clearTimerZero,
  output logic clearExternalOne,
  output logic clearTimerOne,
  output logic idleMode,
  output logic powerDownMode,
  output logic double_baud_select,
  output logic power_fail_reset_enable,
  output logic highActive,
  output logic lowActive
);
  logic [7:0] interruptEnable;
  logic [7:0] interruptPriority;
  logic [7:0] powerControl;
  logic [5:0] sampled;
  logic [5:0] rawFlags;
  logic blockedAccess;
  logic callTaken;
  logic wakeEvent;

  irq_select_if sel ();

  irq_level_arbiter arbiter (
    .sel(sel.arbiter)
  );

  function automatic logic hitsIrqRegs(input logic [7:0] a);
    hitsIrqRegs = (a == ADDR_INTERRUPT_ENABLE) || (a == ADDR_INTERRUPT_PRIORITY);
  endfunction : hitsIrqRegs

  always_comb begin
    rawFlags[SRC_EXT0] = external_zero_flag;
    rawFlags[SRC_TMR0] = timer_zero_overflow_flag;
    rawFlags[SRC_EXT1] = external_one_flag;
    rawFlags[SRC_TMR1] = timer_one_overflow_flag;
    rawFlags[SRC_SER0] = display_channel_flag | serial_receive_flag
      | serial_transmit_flag;
    rawFlags[SRC_SER1] = second_serial_flag;
  end

  // sample once per machine cycle; the poll of the next cycle sees only these
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sampled <= '0;
    end else if (internalReset) begin
      sampled <= '0;
    end else if (stateFivePhaseTwo) begin
      sampled <= rawFlags & interruptEnable[5:0];
    end
  end

  // the instruction under way touched enable or priority, or is a return
  always_comb begin
    blockedAccess = returnFromHandler || ((regWrite || regRead) && hitsIrqRegs(regAddr));
    sel.request = sampled;
    sel.highLevel = interruptPriority[5:0];
  end

  // no pending latch: a blocked request simply vanishes from this decision
  always_comb begin
    callTaken = 1'b0;
    if (pollCycle && finalCycle && !blockedAccess && sel.found
        && interruptEnable[GLOBAL_ENABLE_BIT] && !highActive) begin
      callTaken = sel.foundHigh || !lowActive;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ackRequest <= 1'b0;
      vectorAddress <= VECTOR_BASE;
      pushProgramCounter <= 1'b0;
    end else begin
      ackRequest <= callTaken;
      pushProgramCounter <= callTaken;
      if (callTaken) begin
        vectorAddress <= VECTOR_BASE + VECTOR_STEP * {13'h0000, sel.source};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      popProgramCounter <= 1'b0;
    end else begin
      popProgramCounter <= returnFromHandler;
    end
  end

  // active-level flags; the return clears the higher one in service
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      highActive <= 1'b0;
      lowActive <= 1'b0;
    end else if (internalReset) begin
      highActive <= 1'b0;
      lowActive <= 1'b0;
    end else if (callTaken) begin
      if (sel.foundHigh) begin
        highActive <= 1'b1;
      end else begin
        lowActive <= 1'b1;
      end
    end else if (returnFromHandler) begin
      if (highActive) begin
        highActive <= 1'b0;
      end else begin
        lowActive <= 1'b0;
      end
    end
  end

  // hardware clears only the self-clearing flags; serial flags stay for software
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clearExternalZero <= 1'b0;
      clearTimerZero <= 1'b0;
      clearExternalOne <= 1'b0;
      clearTimerOne <= 1'b0;
    end else begin
      clearExternalZero <= callTaken && sel.source == 3'(SRC_EXT0)
        && external_zero_edge_mode;
      clearTimerZero <= callTaken && sel.source == 3'(SRC_TMR0);
      clearExternalOne <= callTaken && sel.source == 3'(SRC_EXT1)
        && external_one_edge_mode;
      clearTimerOne <= callTaken && sel.source == 3'(SRC_TMR1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interruptEnable <= RESET_INTERRUPT_ENABLE;
    end else if (internalReset) begin
      interruptEnable <= RESET_INTERRUPT_ENABLE;
    end else if (regWrite && regAddr == ADDR_INTERRUPT_ENABLE) begin
      interruptEnable <= regWriteData & MASK_INTERRUPT_ENABLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interruptPriority <= RESET_INTERRUPT_PRIORITY;
    end else if (internalReset) begin
      interruptPriority <= RESET_INTERRUPT_PRIORITY;
    end else if (regWrite && regAddr == ADDR_INTERRUPT_PRIORITY) begin
      interruptPriority <= regWriteData & MASK_INTERRUPT_PRIORITY;
    end
  end

  // any enabled flag sampled wakes idle, even with the global enable off
  assign wakeEvent = callTaken || (stateFivePhaseTwo && |(rawFlags & interruptEnable[5:0]));

  // enable bit survives internal reset; once set, software cannot clear it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      powerControl <= RESET_POWER_CONTROL;
    end else if (internalReset) begin
      powerControl <= RESET_POWER_CONTROL
        | (powerControl & (8'h01 << PFR_ENABLE_BIT));
    end else if (regWrite && regAddr == ADDR_POWER_CONTROL) begin
      powerControl <= (regWriteData & MASK_POWER_CONTROL)
        | (powerControl & (8'h01 << PFR_ENABLE_BIT));
    end else if (wakeEvent) begin
      powerControl[IDLE_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idleMode <= 1'b0;
      powerDownMode <= 1'b0;
      double_baud_select <= 1'b0;
      power_fail_reset_enable <= 1'b0;
    end else begin
      powerDownMode <= powerControl[POWER_DOWN_BIT];
      idleMode <= powerControl[IDLE_BIT] && !powerControl[POWER_DOWN_BIT]
        && !wakeEvent;
      double_baud_select <= powerControl[DOUBLE_BAUD_BIT];
      power_fail_reset_enable <= powerControl[PFR_ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        ADDR_POWER_CONTROL: regReadData <= powerControl;
        ADDR_INTERRUPT_ENABLE: regReadData <= interruptEnable;
        ADDR_INTERRUPT_PRIORITY: regReadData <= interruptPriority;
        default: regReadData <= 8'h00;
      endcase
    end
  end
endmodule : two_level_interrupt_unit

// *** core/irq_unit_pkg.sv ***
// constants and types shared by the two-level interrupt unit
// Summary of operation
// - six sources, each independently placed at low or high level
// - first serial request is OR of display, receive and transmit flags
// - source requests only when enabled; nothing serviced with bit 7 cleared
// - priority bit set means high level, cleared means low level
// - high preempts running low; running high is never preempted
// - high-level request wins over simultaneous low-level request
// - fixed order within level: ext0, tmr0, ext1, tmr1, serial one, serial two
// - flags sampled at state five phase two, evaluated next machine cycle
// - call blocked by equal/higher active, non-final cycle, return or enable/priority access
// - blocked requests are not remembered; every polling cycle is new
// - acknowledge clears timer flags and edge-triggered external flags only
// - acknowledge pushes program counter only and loads vector 0003h..002Bh
// - return clears the active-level flag and pops two bytes into counter
// - enable register at A8h: bit 7 global, bits 5..0 sources, reset 0X00 0000b
// - priority register at B8h: bits 5..0 levels, bits 7..6 reserved
// - idle bit 0 enters idle; cleared by hardware on interrupt or reset
// - power-down bit 1 enters power-down; cleared on reset; wins over idle
// - power control at 87h: bits 7,4,3,2; reset 0XX0 0000b; internal reset keeps bit 4
// - after reset no source enabled and all sources at low level
package irq_unit_pkg;
  localparam int NUM_SOURCES = 6;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'hA8;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY = 8'hB8;
  localparam logic [7:0] RESET_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RESET_INTERRUPT_ENABLE = 8'h00;
  localparam logic [7:0] RESET_INTERRUPT_PRIORITY = 8'h00;
  localparam logic [7:0] MASK_POWER_CONTROL = 8'h9F;
  localparam logic [7:0] MASK_INTERRUPT_ENABLE = 8'hBF;
  localparam logic [7:0] MASK_INTERRUPT_PRIORITY = 8'h3F;
  localparam int GLOBAL_ENABLE_BIT = 7;
  localparam int IDLE_BIT = 0;
  localparam int POWER_DOWN_BIT = 1;
  localparam int PFR_ENABLE_BIT = 4;
  localparam int DOUBLE_BAUD_BIT = 7;
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam logic [15:0] VECTOR_STEP = 16'h0008;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_SER0 = 4;
  localparam int SRC_SER1 = 5;
  localparam logic [2:0] SOURCE_NONE = 3'h7;
endpackage : irq_unit_pkg

// *** core/irq_select_if.sv ***
// carrier between the arbiter and the controller body
`timescale 1ns/1ps
interface irq_select_if;
  logic [5:0] request;
  logic [5:0] highLevel;
  logic found;
  logic foundHigh;
  logic [2:0] source;
  modport arbiter (input request, input highLevel, output found, output foundHigh, output source);
  modport user (output request, output highLevel, input found, input foundHigh, input source);
endinterface : irq_select_if

// *** core/irq_level_arbiter.sv ***
// picks the winning request: high level first, then fixed polling order
`timescale 1ns/1ps
module irq_level_arbiter
  import irq_unit_pkg::*;
(
  irq_select_if.arbiter sel
);
  function automatic logic [2:0] firstSet(input logic [5:0] v);
    firstSet = SOURCE_NONE;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (v[i]) begin
        firstSet = 3'(i);
      end
    end
  endfunction : firstSet

  logic [5:0] hiReq;
  logic [5:0] loReq;
  always_comb begin
    hiReq = sel.request & sel.highLevel;
    loReq = sel.request & ~sel.highLevel;
    sel.found = |sel.request;
    sel.foundHigh = |hiReq;
    sel.source = (|hiReq) ? firstSet(hiReq) : firstSet(loReq);
  end
endmodule : irq_level_arbiter

// *** verification/two_level_interrupt_unit_props.sv ***
// port-level checker for the two-level interrupt unit
`timescale 1ns/1ps
module two_level_interrupt_unit_props(
  input wire logic mclk,
  input wire logic rst,
  input wire logic pollCycle,
  input wire logic finalCycle,
  input wire logic returnFromHandler,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic ackRequest,
  input wire logic [15:0] vectorAddress,
  input wire logic pushProgramCounter,
  input wire logic popProgramCounter,
  input wire logic clearTimerZero,
  input wire logic highActive,
  input wire logic lowActive,
  input wire logic power_fail_reset_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ack_one_cycle_a: assert property (ackRequest |=> !ackRequest)
    else $error("acknowledge longer than one cycle");
  push_with_ack_a: assert property (ackRequest |-> pushProgramCounter)
    else $error("no push with acknowledge");
  vector_legal_a: assert property (ackRequest |-> vectorAddress[2:0] == 3'h3
    && vectorAddress <= 16'h002B) else $error("vector out of table");
  call_needs_poll_a: assert property (ackRequest |-> $past(pollCycle && finalCycle)
    && !$past(returnFromHandler)) else $error("call outside final polling cycle");
  level_set_a: assert property (ackRequest |-> highActive || lowActive)
    else $error("no active level after call");
  high_not_preempted_a: assert property (highActive && !returnFromHandler |=> !ackRequest)
    else $error("high handler preempted");
  pop_after_return_a: assert property (returnFromHandler |=> popProgramCounter)
    else $error("no pop after return");
  timer_clear_a: assert property (clearTimerZero |-> ackRequest && vectorAddress == 16'h000B)
    else $error("timer flag cleared without its call");
  enable_access_a: assert property (regWrite && regAddr == 8'hA8 |=> !ackRequest)
    else $error("call during enable access");
  power_fail_reset_enable_sticky_a: assert property (power_fail_reset_enable |=> power_fail_reset_enable)
    else $error("power fail enable dropped");
endmodule : two_level_interrupt_unit_props
bind two_level_interrupt_unit two_level_interrupt_unit_props chk (.mclk(mclk), .rst(rst),
  .pollCycle(pollCycle), .finalCycle(finalCycle), .returnFromHandler(returnFromHandler),
  .regWrite(regWrite), .regAddr(regAddr), .ackRequest(ackRequest), .vectorAddress(vectorAddress),
  .pushProgramCounter(pushProgramCounter), .popProgramCounter(popProgramCounter),
  .clearTimerZero(clearTimerZero), .highActive(highActive), .lowActive(lowActive),
  .power_fail_reset_enable(power_fail_reset_enable));

// *** verification/irq_flag_source.sv ***
// peripheral model holding the eight request flags
`timescale 1ns/1ps
module irq_flag_source(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] setFlag,
  input wire logic [7:0] swClear,
  input wire logic [3:0] hwClear,
  output logic [7:0] flags
);
  // only timer and external flags see the hardware clear, serial ones wait for software
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) flags <= 8'h00;
    else flags <= (flags & ~swClear & ~{4'h0, hwClear}) | setFlag;
  end
endmodule : irq_flag_source

// *** verification/two_level_interrupt_unit_tb_top.sv ***
// self-checking bench for the two-level interrupt unit
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module two_level_interrupt_unit_tb_top;
  import irq_unit_pkg::*;
  logic mclk = 0, rst = 1, internalReset = 0, s5 = 0, pollCycle = 0, finalCycle = 0;
  logic returnFromHandler = 0, regWrite = 0, regRead = 0, ext0Edge = 1, ext1Edge = 0;
  logic [7:0] regAddr = 8'h00, regWriteData = 8'h00, setFlag = 8'h00, swClear = 8'h00;
  logic [7:0] flags, regReadData, rd;
  logic [15:0] vectorAddress, v;
  logic [3:0] hwClear;
  logic ackRequest, pushProgramCounter, popProgramCounter, idleMode, powerDownMode, ack, pu;
  logic double_baud_select, power_fail_reset_enable, highActive, lowActive;
  int errors = 0, checks_done = 0;
  initial forever #2 mclk = ~mclk;
  irq_flag_source far (.mclk(mclk), .rst(rst), .setFlag(setFlag), .swClear(swClear),
    .hwClear(hwClear), .flags(flags));
  two_level_interrupt_unit uut (.mclk(mclk), .rst(rst), .internalReset(internalReset),
    .stateFivePhaseTwo(s5), .pollCycle(pollCycle), .finalCycle(finalCycle),
    .returnFromHandler(returnFromHandler), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWriteData(regWriteData), .external_zero_flag(flags[0]),
    .external_zero_edge_mode(ext0Edge), .timer_zero_overflow_flag(flags[1]),
    .external_one_flag(flags[2]), .external_one_edge_mode(ext1Edge),
    .timer_one_overflow_flag(flags[3]), .display_channel_flag(flags[4]),
    .serial_receive_flag(flags[5]), .serial_transmit_flag(flags[6]),
    .second_serial_flag(flags[7]), .regReadData(regReadData), .ackRequest(ackRequest),
    .vectorAddress(vectorAddress), .pushProgramCounter(pushProgramCounter),
    .popProgramCounter(popProgramCounter), .clearExternalZero(hwClear[0]),
    .clearTimerZero(hwClear[1]), .clearExternalOne(hwClear[2]), .clearTimerOne(hwClear[3]),
    .idleMode(idleMode), .powerDownMode(powerDownMode),
    .double_baud_select(double_baud_select),
    .power_fail_reset_enable(power_fail_reset_enable), .highActive(highActive),
    .lowActive(lowActive));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) begin regWrite = 1; regAddr = a; regWriteData = d; end
    @(negedge mclk) regWrite = 0;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk) begin regRead = 1; regAddr = a; end
    @(negedge mclk) regRead = 0;
    `CHK(regReadData, e)
  endtask : rdchk
  task automatic pulse_flags(input logic [7:0] m, input logic clr);
    @(negedge mclk) if (clr) swClear = m; else setFlag = m;
    @(negedge mclk) begin swClear = 8'h00; setFlag = 8'h00; end
  endtask : pulse_flags
  // sample, idle cycle, poll; ack is registered so it shows one cycle after the poll
  task automatic mc(input logic fin);
    @(negedge mclk) s5 = 1;
    @(negedge mclk) s5 = 0;
    @(negedge mclk) begin pollCycle = 1; finalCycle = fin; end
    @(negedge mclk) begin
      pollCycle = 0;
      finalCycle = 0;
      ack = ackRequest;
      v = vectorAddress;
      pu = pushProgramCounter;
    end
  endtask : mc
  task automatic ret();
    @(negedge mclk) returnFromHandler = 1;
    @(negedge mclk) returnFromHandler = 0;
    `CHK(popProgramCounter, 1'b1)
  endtask : ret
  task automatic test_registers();
    rdchk(8'hA8, 8'h00); rdchk(8'hB8, 8'h00); rdchk(8'h87, 8'h00);
    wr(8'hA8, 8'hBF); rdchk(8'hA8, 8'hBF);
    wr(8'hB8, 8'h3F); rdchk(8'hB8, 8'h3F);
    rdchk(8'h80, 8'h00);
    wr(8'h87, 8'h9C); rdchk(8'h87, 8'h9C); `CHK(double_baud_select, 1'b1)
    wr(8'h87, 8'h00); rdchk(8'h87, 8'h10); wr(8'hB8, 8'h00);
    $display("test_registers done");
  endtask : test_registers
  task automatic test_vectors();
    int s;
    for (int b = 0; b < 8; b++) begin
      s = b < 4 ? b : (b < 7 ? 4 : 5);
      pulse_flags(8'(1 << b), 0); mc(1);
      `CHK(ack, 1'b1) `CHK(v, 16'h0003 + 16'(8 * s))
      `CHK(pu, 1'b1)
      @(negedge mclk) `CHK(flags[b], (b == 2 || b > 3))
      pulse_flags(8'hFF, 1); ret();
    end
    $display("test_vectors done");
  endtask : test_vectors
  task automatic test_levels();
    pulse_flags(8'hFF, 0); mc(1); `CHK(v, 16'h0003) `CHK(lowActive, 1'b1)
    wr(8'hB8, 8'h20); mc(1); `CHK(ack, 1'b1) `CHK(v, 16'h002B)
    `CHK(highActive, 1'b1) mc(1); `CHK(ack, 1'b0)
    ret(); pulse_flags(8'h80, 1);
    mc(1); `CHK(ack, 1'b0) `CHK(highActive, 1'b0)
    ret(); mc(0); `CHK(ack, 1'b0)
    wr(8'hA8, 8'h3F); mc(1); `CHK(ack, 1'b0)
    pulse_flags(8'hFF, 1); wr(8'hA8, 8'hBF); mc(1); `CHK(ack, 1'b0)
    wr(8'hB8, 8'h00); $display("test_levels done");
  endtask : test_levels
  task automatic test_power();
    wr(8'h87, 8'h01);
    @(negedge mclk) `CHK(idleMode, 1'b1)
    pulse_flags(8'h01, 0); mc(1); `CHK(ack, 1'b1) `CHK(idleMode, 1'b0)
    pulse_flags(8'hFF, 1); ret();
    wr(8'h87, 8'h03);
    @(negedge mclk) `CHK(powerDownMode, 1'b1) `CHK(idleMode, 1'b0)
    @(negedge mclk) internalReset = 1;
    @(negedge mclk) internalReset = 0;
    @(negedge mclk) `CHK(powerDownMode, 1'b0)
    `CHK(power_fail_reset_enable, 1'b1)
    rdchk(8'h87, 8'h10); rdchk(8'hA8, 8'h00);
    $display("test_power done");
  endtask : test_power
  // a pending, enabled request meets a poll that a return or an enable access blocks
  task automatic test_blocked_poll(input logic viaReturn);
    pulse_flags(8'h01, 0);
    @(negedge mclk) s5 = 1;
    @(negedge mclk) begin
      s5 = 0;
      pollCycle = 1;
      finalCycle = 1;
      returnFromHandler = viaReturn;
      regWrite = !viaReturn;
      regAddr = 8'hA8;
      regWriteData = 8'hBF;
    end
    @(negedge mclk) begin
      pollCycle = 0;
      finalCycle = 0;
      returnFromHandler = 0;
      regWrite = 0;
    end
    `CHK(ackRequest, 1'b0)
    `CHK(flags[0], 1'b1)
    pulse_flags(8'h01, 1);
    $display("test_blocked_poll done");
  endtask : test_blocked_poll
  // level-triggered external zero keeps its flag, edge-triggered external one loses it
  task automatic test_edge_modes();
    ext0Edge = 0;
    ext1Edge = 1;
    pulse_flags(8'h05, 0); mc(1); `CHK(v, 16'h0003)
    @(negedge mclk) `CHK(flags[0], 1'b1)
    pulse_flags(8'h01, 1); ret();
    mc(1); `CHK(ack, 1'b1) `CHK(v, 16'h0013)
    @(negedge mclk) `CHK(flags[2], 1'b0)
    ret();
    ext0Edge = 1;
    ext1Edge = 0;
    $display("test_edge_modes done");
  endtask : test_edge_modes
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(negedge mclk);
    rst = 0;
    test_registers(); test_vectors(); test_levels();
    test_blocked_poll(1'b0); test_blocked_poll(1'b1); test_edge_modes(); test_power();
    tally_and_finish();
  end
  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end
endmodule : two_level_interrupt_unit_tb_top
